// ### logic/ep0_ctrl_pkg.sv
// Package: register map, field layout and engine event types for the endpoint-zero block
package ep0_ctrl_pkg;

  // Register offsets (bank 0)
  localparam logic [7:0] FRAME_NUMBER_HIGH_ADDR     = 8'h32;
  localparam logic [7:0] ENDPOINT_ZERO_CONTROL_ADDR = 8'h36;

  // Control register field positions
  localparam int SETUP_BIT = 7;
  localparam int IN_BIT    = 6;
  localparam int OUT_BIT   = 5;
  localparam int ACKED_BIT = 4;
  localparam int MODE_MSB  = 3;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [2:0] FRAME_RESET   = 3'h0;

  // Mode encodings
  localparam logic [3:0] MODE_DISABLE    = 4'h0;
  localparam logic [3:0] MODE_NAK_INOUT  = 4'h1;
  localparam logic [3:0] MODE_STATUS_OUT = 4'h2;
  localparam logic [3:0] MODE_STALL      = 4'h3;
  localparam logic [3:0] MODE_STATUS_IN  = 4'h6;
  localparam logic [3:0] MODE_NAK_OUT    = 4'h8;
  localparam logic [3:0] MODE_ACK_OUT    = 4'h9;
  localparam logic [3:0] MODE_ACK_OUT_SI = 4'hb;
  localparam logic [3:0] MODE_NAK_IN     = 4'hc;
  localparam logic [3:0] MODE_ACK_IN     = 4'hd;
  localparam logic [3:0] MODE_ACK_IN_SO  = 4'hf;

  // Token kinds seen by the engine
  typedef enum logic [1:0] {
    TOK_SETUP,
    TOK_IN,
    TOK_OUT
  } token_e;

  // Handshake answers the engine gives
  typedef enum logic [1:0] {
    RESP_IGNORE,
    RESP_ACK,
    RESP_NAK,
    RESP_STALL
  } resp_e;

  // Events reported by the protocol engine, one-cycle pulses except the frame and eng_mode values
  typedef struct packed {
    logic setup_data_start; // Setup data phase begins
    logic setup_ack_start;  // Device ACK to setup begins
    logic in_acked;         // Host ACKed our IN data
    logic out_acked;        // Last OUT packet ACKed by us
    logic xfer_acked;       // Any transaction ended in ACK
    logic sof_valid;        // Valid start-of-frame token
    logic [10:0] frame;     // Frame count from the token
    logic eng_wr;           // Engine writes control/count
    logic [3:0] eng_mode;   // Mode the engine writes
  } engine_evt_s;

  // Processor register port
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;         // io write strobe
    logic       rd;         // io read strobe
    logic [7:0] wdata;
  } cpu_req_s;

endpackage

// ### logic/usb_endpoint0_control_status.sv
// Endpoint-zero control/status register, write interlock and frame number high bits
`timescale 1ns/1ps
module usb_endpoint0_control_status (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstn,
  // Processor register access
  input  wire ep0_ctrl_pkg::cpu_req_s     cpu_req,
  output logic [7:0]                      cpu_rdata,
  // Data register write gating
  input  wire logic                       data_wr_req,
  output logic                            data_wr_allow,
  // Protocol engine events and queries
  input  wire ep0_ctrl_pkg::engine_evt_s  evt,
  input  wire ep0_ctrl_pkg::token_e       tok,
  input  wire logic                       tok_valid,
  input  wire logic                       zero_len,
  input  wire logic                       stall_bit,
  output ep0_ctrl_pkg::resp_e             resp,
  output logic [3:0]                      mode,
  output logic                            locked
);

  logic       setup_q, in_q, out_q, acked_q;
  logic [3:0] mode_q;
  logic       lock_q;
  logic       force_q;
  logic [2:0] frame_hi_q;
  logic [7:0] rdata_q;
  logic       dwa_q;
  ep0_ctrl_pkg::resp_e resp_q;
  logic       ctl_sel, cpu_wr_ok, cpu_rd_ctl;

  // Address decode for the control register
  assign ctl_sel    = cpu_req.addr == ep0_ctrl_pkg::ENDPOINT_ZERO_CONTROL_ADDR;
  assign cpu_rd_ctl = ctl_sel && cpu_req.rd;
  assign cpu_wr_ok  = ctl_sel && cpu_req.wr && !lock_q;

  // Write lock; engine write wins over a same-cycle read release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lock_q <= 1'b0;
    end else if (evt.eng_wr) begin
      lock_q <= 1'b1;
    end else if (cpu_rd_ctl) begin
      lock_q <= 1'b0;
    end
  end

  // Forced interval of the setup flag
  always_ff @(posedge clk) begin
    if (!rstn) begin
      force_q <= 1'b0;
    end else if (evt.setup_data_start) begin
      force_q <= 1'b1;
    end else if (evt.setup_ack_start) begin
      force_q <= 1'b0;
    end
  end

  // Status flags: hardware set wins over processor clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      setup_q <= 1'b0;
      in_q    <= 1'b0;
      out_q   <= 1'b0;
      acked_q <= 1'b0;
    end else begin
      if (evt.setup_data_start || force_q) begin
        setup_q <= 1'b1;
      end else if (cpu_wr_ok) begin
        setup_q <= 1'b0;
      end
      if (evt.in_acked) begin
        in_q <= 1'b1;
      end else if (cpu_wr_ok) begin
        in_q <= 1'b0;
      end
      if (evt.out_acked) begin
        out_q <= 1'b1;
      end else if (cpu_wr_ok) begin
        out_q <= 1'b0;
      end
      if (evt.xfer_acked) begin
        acked_q <= 1'b1;
      end else if (cpu_wr_ok) begin
        acked_q <= 1'b0;
      end
    end
  end

  // Mode field: engine writes and auto-updates take priority over processor
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_q <= ep0_ctrl_pkg::CONTROL_RESET[ep0_ctrl_pkg::MODE_MSB:0];
    end else if (evt.eng_wr) begin
      mode_q <= evt.eng_mode;
    end else if (evt.out_acked && mode_q == ep0_ctrl_pkg::MODE_ACK_OUT && !stall_bit) begin
      mode_q <= ep0_ctrl_pkg::MODE_NAK_OUT;
    end else if (evt.in_acked && mode_q == ep0_ctrl_pkg::MODE_ACK_IN && !stall_bit) begin
      mode_q <= ep0_ctrl_pkg::MODE_NAK_IN;
    end else if (cpu_wr_ok) begin
      mode_q <= cpu_req.wdata[ep0_ctrl_pkg::MODE_MSB:0];
    end
  end

  // Frame number high bits, captured on each valid start-of-frame
  always_ff @(posedge clk) begin
    if (!rstn) begin
      frame_hi_q <= ep0_ctrl_pkg::FRAME_RESET;
    end else if (evt.sof_valid) begin
      frame_hi_q <= evt.frame[10:8];
    end
  end

  // Read data; reserved frame bits read as zero, writes there are ignored
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (cpu_req.rd) begin
      unique case (cpu_req.addr)
        ep0_ctrl_pkg::ENDPOINT_ZERO_CONTROL_ADDR:
          rdata_q <= {setup_q, in_q, out_q, acked_q, mode_q};
        ep0_ctrl_pkg::FRAME_NUMBER_HIGH_ADDR:
          rdata_q <= {5'h00, frame_hi_q};
        default:
          rdata_q <= 8'h00;
      endcase
    end
  end

  // Data register write gate; stays shut while a setup is pending or forced
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dwa_q <= 1'b0;
    end else begin
      dwa_q <= data_wr_req && !setup_q && !force_q && !lock_q;
    end
  end

  // Handshake choice per mode and token
  always_ff @(posedge clk) begin
    if (!rstn) begin
      resp_q <= ep0_ctrl_pkg::RESP_IGNORE;
    end else if (!tok_valid) begin
      resp_q <= ep0_ctrl_pkg::RESP_IGNORE;
    end else begin
      resp_q <= ep0_ctrl_pkg::RESP_IGNORE;
      unique case (tok)
        ep0_ctrl_pkg::TOK_SETUP: begin
          if (mode_q inside {ep0_ctrl_pkg::MODE_NAK_INOUT, ep0_ctrl_pkg::MODE_STATUS_OUT,
                             ep0_ctrl_pkg::MODE_STALL, ep0_ctrl_pkg::MODE_STATUS_IN,
                             ep0_ctrl_pkg::MODE_ACK_OUT_SI, ep0_ctrl_pkg::MODE_ACK_IN_SO})
            resp_q <= ep0_ctrl_pkg::RESP_ACK;
        end
        ep0_ctrl_pkg::TOK_IN: begin
          unique case (mode_q)
            ep0_ctrl_pkg::MODE_NAK_INOUT, ep0_ctrl_pkg::MODE_NAK_IN:
              resp_q <= ep0_ctrl_pkg::RESP_NAK;
            ep0_ctrl_pkg::MODE_STATUS_OUT, ep0_ctrl_pkg::MODE_STALL:
              resp_q <= ep0_ctrl_pkg::RESP_STALL;
            ep0_ctrl_pkg::MODE_ACK_IN:
              resp_q <= stall_bit ? ep0_ctrl_pkg::RESP_STALL
                                  : ep0_ctrl_pkg::RESP_ACK;
            ep0_ctrl_pkg::MODE_STATUS_IN, ep0_ctrl_pkg::MODE_ACK_OUT_SI,
            ep0_ctrl_pkg::MODE_ACK_IN_SO:
              resp_q <= ep0_ctrl_pkg::RESP_ACK;
            default:
              resp_q <= ep0_ctrl_pkg::RESP_IGNORE;
          endcase
        end
        ep0_ctrl_pkg::TOK_OUT: begin
          unique case (mode_q)
            ep0_ctrl_pkg::MODE_NAK_INOUT, ep0_ctrl_pkg::MODE_NAK_OUT:
              resp_q <= ep0_ctrl_pkg::RESP_NAK;
            ep0_ctrl_pkg::MODE_STALL, ep0_ctrl_pkg::MODE_STATUS_IN:
              resp_q <= ep0_ctrl_pkg::RESP_STALL;
            ep0_ctrl_pkg::MODE_STATUS_OUT, ep0_ctrl_pkg::MODE_ACK_IN_SO:
              resp_q <= zero_len ? ep0_ctrl_pkg::RESP_ACK
                                 : ep0_ctrl_pkg::RESP_STALL;
            ep0_ctrl_pkg::MODE_ACK_OUT:
              resp_q <= stall_bit ? ep0_ctrl_pkg::RESP_STALL
                                  : ep0_ctrl_pkg::RESP_ACK;
            ep0_ctrl_pkg::MODE_ACK_OUT_SI:
              resp_q <= ep0_ctrl_pkg::RESP_ACK;
            default:
              resp_q <= ep0_ctrl_pkg::RESP_IGNORE;
          endcase
        end
        default:
          resp_q <= ep0_ctrl_pkg::RESP_IGNORE;
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign cpu_rdata     = rdata_q;
  assign data_wr_allow = dwa_q;
  assign resp          = resp_q;
  assign mode          = mode_q;
  assign locked        = lock_q;

endmodule

// ### verif/ep0_chk.sv
// Checker for the endpoint-zero control block
`timescale 1ns/1ps
module ep0_chk (
  // Clock and reset
  input logic                      clk,
  input logic                      rstn,
  // Processor side
  input ep0_ctrl_pkg::cpu_req_s    cpu_req,
  input logic [7:0]                cpu_rdata,
  input logic                      data_wr_req,
  input logic                      data_wr_allow,
  // Engine side
  input ep0_ctrl_pkg::engine_evt_s evt,
  input ep0_ctrl_pkg::token_e      tok,
  input logic                      tok_valid,
  input logic                      stall_bit,
  input ep0_ctrl_pkg::resp_e       resp,
  input logic [3:0]                mode,
  input logic                      locked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Control strobes; q means nothing else moves the mode
  wire w = cpu_req.wr && cpu_req.addr == ep0_ctrl_pkg::ENDPOINT_ZERO_CONTROL_ADDR;
  wire r = cpu_req.rd && cpu_req.addr == ep0_ctrl_pkg::ENDPOINT_ZERO_CONTROL_ADDR;
  wire q = !evt.eng_wr && !evt.in_acked && !evt.out_acked;
  wire f = cpu_req.rd && cpu_req.addr == ep0_ctrl_pkg::FRAME_NUMBER_HIGH_ADDR;
  wire [2:0] fh = evt.frame[10:8];
  // Frame read two cycles after a start of frame
  sequence s_sof;
    evt.sof_valid ##1 !evt.sof_valid ##1 (f && !evt.sof_valid);
  endsequence
  // Data write asked while setup is forced
  sequence s_setup;
    evt.setup_data_start ##1 !evt.setup_ack_start ##1 data_wr_req;
  endsequence
  a_engine_locks: assert property (evt.eng_wr |=> locked)
    else $error("no lock");
  a_read_unlocks: assert property (r && !evt.eng_wr |=> !locked)
    else $error("lock kept");
  a_locked_refused: assert property (w && locked && q |=> $stable(mode))
    else $error("locked write taken");
  a_write_mode: assert property (
    w && !locked && q |=> mode == $past(cpu_req.wdata[3:0]))
    else $error("mode not written");
  a_out_auto: assert property (
    evt.out_acked && !evt.eng_wr && !stall_bit && mode == 4'h9 |=> mode == 4'h8)
    else $error("no NAK-OUT move");
  a_in_auto: assert property (
    evt.in_acked && !evt.eng_wr && !stall_bit && mode == 4'hd |=> mode == 4'hc)
    else $error("no NAK-IN move");
  a_status_stall: assert property (
    tok_valid && tok == ep0_ctrl_pkg::TOK_IN && mode == 4'h2
    |=> resp == ep0_ctrl_pkg::RESP_STALL)
    else $error("IN not stalled");
  a_frame_read: assert property (s_sof |=> cpu_rdata == {5'h00, $past(fh, 3)})
    else $error("frame bits wrong");
  a_setup_gate: assert property (s_setup |=> !data_wr_allow)
    else $error("data write allowed");
endmodule
bind usb_endpoint0_control_status ep0_chk chk (.clk(clk), .rstn(rstn), .cpu_req(cpu_req),
  .cpu_rdata(cpu_rdata), .data_wr_req(data_wr_req), .data_wr_allow(data_wr_allow), .evt(evt),
  .tok(tok), .tok_valid(tok_valid), .stall_bit(stall_bit), .resp(resp), .mode(mode),
  .locked(locked));

// ### verif/tb_usb_endpoint0_control_status.sv
// Self-checking bench for the endpoint-zero control block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb_usb_endpoint0_control_status;
  localparam logic [7:0] CR = ep0_ctrl_pkg::ENDPOINT_ZERO_CONTROL_ADDR;
  localparam logic [7:0] FH = ep0_ctrl_pkg::FRAME_NUMBER_HIGH_ADDR;
  logic                      clk, rstn, data_wr_req, data_wr_allow;
  logic                      tok_valid, zero_len, stall_bit, locked;
  logic [7:0]                cpu_rdata;
  logic [3:0]                mode;
  ep0_ctrl_pkg::cpu_req_s    cpu_req;
  ep0_ctrl_pkg::engine_evt_s evt;
  ep0_ctrl_pkg::token_e      tok;
  ep0_ctrl_pkg::resp_e       resp;
  int                        n_errors, checks, cycles;
  usb_endpoint0_control_status dut (.clk(clk), .rstn(rstn), .cpu_req(cpu_req),
    .cpu_rdata(cpu_rdata), .data_wr_req(data_wr_req), .data_wr_allow(data_wr_allow),
    .evt(evt), .tok(tok), .tok_valid(tok_valid), .zero_len(zero_len),
    .stall_bit(stall_bit), .resp(resp), .mode(mode), .locked(locked));
  usb_host_model host (.clk(clk), .evt(evt), .tok(tok), .tok_valid(tok_valid),
    .zero_len(zero_len), .stall_bit(stall_bit));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard, well above the run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One-cycle register access, address held, data inverted after
  task automatic io(input logic [7:0] a, input logic r, w, input logic [7:0] d);
    @(posedge clk) cpu_req <= '{addr: a, wr: w, rd: r, wdata: d};
    @(posedge clk) cpu_req <= '{addr: a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    #1;
  endtask
  task automatic rd(input logic [7:0] a, e);
    io(a, 1'b1, 1'b0, 8'h00);
    `CHK(cpu_rdata, e)
  endtask
  task automatic dw(input logic e);
    @(posedge clk) data_wr_req <= 1'b1;
    @(posedge clk) data_wr_req <= 1'b0;
    #1;
    `CHK(data_wr_allow, e)
  endtask
  initial begin
    cpu_req = '0;
    data_wr_req = 1'b0;
    rstn = 1'b0;
    n_errors = 0;
    checks = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(CR, ep0_ctrl_pkg::CONTROL_RESET);
    `CHK(locked, 1'b0)
    rd(FH, 8'h00);
    // Status bits drop whatever is written
    io(CR, 1'b0, 1'b1, 8'hf9);
    rd(CR, 8'h09);
    host.pulse('{out_acked: 1'b1, xfer_acked: 1'b1, default: '0});
    rd(CR, 8'h38);
    io(CR, 1'b0, 1'b1, 8'h0d);
    rd(CR, 8'h0d);
    host.pulse('{in_acked: 1'b1, xfer_acked: 1'b1, default: '0});
    rd(CR, 8'h5c);
    // Engine write locks until the control register is read
    io(CR, 1'b0, 1'b1, 8'h00);
    // Acked flag set with the lock, so a refused write must keep it
    host.pulse('{eng_wr: 1'b1, xfer_acked: 1'b1, eng_mode: 4'h2, default: '0});
    `CHK(locked, 1'b1)
    io(CR, 1'b0, 1'b1, 8'h01);
    rd(CR, 8'h12);
    `CHK(locked, 1'b0)
    host.token(ep0_ctrl_pkg::TOK_IN, 1'b0);
    `CHK(resp, ep0_ctrl_pkg::RESP_STALL)
    host.token(ep0_ctrl_pkg::TOK_OUT, 1'b1);
    `CHK(resp, ep0_ctrl_pkg::RESP_ACK)
    host.token(ep0_ctrl_pkg::TOK_SETUP, 1'b0);
    `CHK(resp, ep0_ctrl_pkg::RESP_ACK)
    io(CR, 1'b0, 1'b1, 8'h01);
    host.token(ep0_ctrl_pkg::TOK_IN, 1'b0);
    `CHK(resp, ep0_ctrl_pkg::RESP_NAK)
    // Move-immediate: write refused, strobe still unlocks
    host.pulse('{eng_wr: 1'b1, eng_mode: 4'h3, default: '0});
    io(CR, 1'b1, 1'b1, 8'h01);
    `CHK(locked, 1'b0)
    rd(CR, 8'h03);
    // Stall bit turns the ACK-OUT answer into STALL
    io(CR, 1'b0, 1'b1, 8'h09);
    host.set_stall(1'b1);
    host.token(ep0_ctrl_pkg::TOK_OUT, 1'b0);
    `CHK(resp, ep0_ctrl_pkg::RESP_STALL)
    host.set_stall(1'b0);
    host.token(ep0_ctrl_pkg::TOK_OUT, 1'b0);
    `CHK(resp, ep0_ctrl_pkg::RESP_ACK)
    // Setup phase forces its flag and gates data writes
    host.pulse('{setup_data_start: 1'b1, default: '0});
    dw(1'b0);
    io(CR, 1'b0, 1'b1, 8'h00);
    host.pulse('{setup_ack_start: 1'b1, xfer_acked: 1'b1, default: '0});
    rd(CR, 8'h90);
    io(CR, 1'b0, 1'b1, 8'h00);
    dw(1'b1);
    // Upper frame bits, read-only
    host.pulse('{sof_valid: 1'b1, frame: 11'h5a3, default: '0});
    rd(FH, 8'h05);
    io(FH, 1'b0, 1'b1, 8'h00);
    rd(FH, 8'h05);
    // Reset in mid-run drops lock, flags and frame bits
    host.pulse('{eng_wr: 1'b1, in_acked: 1'b1, eng_mode: 4'h6, default: '0});
    `CHK(locked, 1'b1)
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    `CHK(locked, 1'b0)
    rd(CR, ep0_ctrl_pkg::CONTROL_RESET);
    rd(FH, 8'h00);
    final_report();
  end
endmodule

// ### verif/usb_host_model.sv
// Engine stand-in raising events and tokens toward the block
`timescale 1ns/1ps
module usb_host_model (
  // Clock
  input logic                       clk,
  // Engine outputs
  output ep0_ctrl_pkg::engine_evt_s evt,
  output ep0_ctrl_pkg::token_e      tok,
  output logic                      tok_valid,
  output logic                      zero_len,
  output logic                      stall_bit
);
  // Idle; stall clear until a test sets it
  initial begin
    evt = '0;
    tok = ep0_ctrl_pkg::TOK_SETUP;
    tok_valid = 1'b0;
    zero_len = 1'b0;
    stall_bit = 1'b0;
  end
  // One-cycle event; frame lines inverted once released
  task automatic pulse(input ep0_ctrl_pkg::engine_evt_s e);
    @(posedge clk) evt <= e;
    @(posedge clk) evt <= '{frame: ~e.frame, default: '0};
    #1;
  endtask
  // Stall bit change, seen from the next edge on
  task automatic set_stall(input logic s);
    @(posedge clk) stall_bit <= s;
    #1;
  endtask
  // One token; answer due a cycle after it is taken
  task automatic token(input ep0_ctrl_pkg::token_e t, input logic z);
    @(posedge clk) begin
      tok <= t;
      tok_valid <= 1'b1;
      zero_len <= z;
    end
    @(posedge clk) begin
      tok_valid <= 1'b0;
      zero_len <= ~z;
    end
    #1;
  endtask
endmodule
